// ==== srl_bcd_addr.sv ====
// bcd station address check and conversion to binary
// assumes a stable input word; purely combinational
`include "srl_regs.svh"
module srl_bcd_addr (
    // raw bcd address byte
    input wire logic [`SRL_ADDR_BITS-1:0] bcd,
    // converted address and its flag
    output logic [6:0] bin,
    output logic bad
);
    function automatic logic digit_ok(input logic [3:0] nib);
        digit_ok = (nib <= `SRL_BCD_DIGIT_MAX);
    endfunction : digit_ok

    logic [6:0] conv;

    always_comb begin
        conv = ({3'b000, bcd[7:4]} * `SRL_BCD_TEN) + {3'b000, bcd[3:0]}; // [RULE_08]
        bad = !digit_ok(bcd[7:4]) || !digit_ok(bcd[3:0]) || (bcd == 8'h00); // [RULE_07]
        bin = bad ? `SRL_ADDR_DEFAULT : conv; // [RULE_07]
    end
endmodule : srl_bcd_addr

// ==== srl_chain_model.sv ====
// behavioural model of the external parallel-load chain holding the switches
// assumes load and enable active low at the chain, shift on rising shift clock
module srl_chain_model #(
    parameter int DLY = 0
) (
    // chain control from the loader
    input wire logic chain_clock_enable_out,
    input wire logic param_shift_clock,
    input wire logic parallel_load_strobe,
    // switch settings and serial data back
    input wire logic [23:0] switches,
    output logic param_serial_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [23:0] sh = 24'h5a_5a5a;

    // load wins over shift; refill toggles so stale bits never look valid
    always @(posedge param_shift_clock or negedge parallel_load_strobe) begin
        if (!parallel_load_strobe) begin
            sh <= switches;
        end else if (!chain_clock_enable_out) begin
            sh <= {~sh[0], sh[23:1]};
        end
    end

    // slow chains are modelled by a nonzero delay
    assign #(DLY) param_serial_in = sh[0];
endmodule : srl_chain_model

// ==== srl_param_loader.sv ====
// parameter loader: reads station address and id number from an external
// parallel-load shift register chain, with an ahb-lite register slave.
// assumes link_clk runs free; chain pins and select straps are asynchronous.
//
// What this block does
// RULE_01: use the chain only when serial params selected and eeprom select low
// RULE_02: each received bit enters the internal register at bit 23
// RULE_03: each shift moves the internal register one place toward bit 0
// RULE_04: chain gives station address lsb first, then id number from bit 0
// RULE_05: one transfer is exactly 24 bits: 8 address, 16 id
// RULE_06: external station address is bcd, from 1 to 99
// RULE_07: zero or bad bcd digit gives station address 126
// RULE_08: valid bcd address is converted to binary for address compare
// RULE_09: a read cycle starts only when the request flag is set
// RULE_10: finishing a read cycle clears the request flag as acknowledge
// RULE_11: after every reset a read is requested
// RULE_12: after reset: clock enable high, shift clock low, load strobe high
// RULE_13: controller drives shift clock, clock enable and load strobe
// RULE_14: parallel load comes first, serial clocking afterwards
// RULE_15: controller runs at 250 kHz
// RULE_16: one complete read takes 96 microseconds
// RULE_17: parameters are taken over only after all 24 bits arrived
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`include "srl_regs.svh"
module srl_param_loader (
    // system clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // mode straps
    input wire logic serial_param_select,
    input wire logic eeprom_select,
    // link clock and chain pins
    input wire logic link_clk,
    input wire logic param_serial_in,
    output logic chain_clock_enable_out,
    output logic param_shift_clock,
    output logic parallel_load_strobe,
    // parameters to the rest of the device
    input wire logic [`SRL_ADDR_BITS-1:0] destination_address,
    output logic [6:0] station_address,
    output logic [`SRL_ID_BITS-1:0] id_number,
    output logic param_valid,
    output logic address_match,
    output logic shift_read_request
);
    import srl_pkg::*;

    localparam logic [4:0] DIV_LAST = 5'(`SRL_TICK_DIV - 1);
    localparam logic [4:0] HALF_LAST = 5'((`SRL_TICK_DIV / 2) - 1);
    localparam logic [4:0] TICK_LAST = 5'(`SRL_READ_TICKS - 1);
    localparam int c_done_dly = `SRL_READ_CYCLES + 1;

    srl_sys_s s;
    srl_sys_s next_s;
    srl_lk_s l;
    srl_lk_s next_l;

    logic link_rst;
    logic sin;
    logic req_sync;
    logic done_sync;
    logic sel_sync;
    logic ee_sync;
    logic mode_ok;
    logic sw_set;
    logic done_edge;
    logic accept;
    logic lk_sample;
    logic lk_start;
    logic [6:0] bcd_bin;
    logic bcd_bad;

    // crossings into the link domain
    srl_sync u_rst_sync (
        .clk(link_clk),
        .d(s.link_hold),
        .q(link_rst)
    );
    srl_sync u_sin_sync (
        .clk(link_clk),
        .d(param_serial_in),
        .q(sin)
    );
    srl_sync u_req_sync (
        .clk(link_clk),
        .d(s.req_tgl),
        .q(req_sync)
    );

    // crossings into the system domain
    srl_sync u_done_sync (
        .clk(clk),
        .d(l.done_tgl),
        .q(done_sync)
    );
    srl_sync u_sel_sync (
        .clk(clk),
        .d(serial_param_select),
        .q(sel_sync)
    );
    srl_sync u_ee_sync (
        .clk(clk),
        .d(eeprom_select),
        .q(ee_sync)
    );

    // result word is written with the done toggle and stays stable until the next read finishes
    srl_bcd_addr u_bcd (
        .bcd(l.result[`SRL_ADDR_BITS-1:0]),
        .bin(bcd_bin),
        .bad(bcd_bad)
    );

    assign mode_ok = sel_sync && !ee_sync; // [RULE_01]
    assign done_edge = (done_sync != s.done_seen) && !s.link_hold;
    assign accept = hsel && htrans[1] && hready;
    assign sw_set = s.dp_valid && s.dp_write && (s.dp_addr == `SRL_OFS_CTRL)
        && hwdata[`SRL_CTRL_REQ_BIT];

    // system domain
    always_comb begin
        next_s = s;
        next_s.done_seen = done_sync;
        next_s.link_hold = 1'b0;
        next_s.dp_valid = accept;
        next_s.dp_write = hwrite;
        next_s.dp_addr = haddr[7:0];
        next_s.hrdata = 32'h0000_0000;
        if (done_edge) begin
            next_s.busy = 1'b0;
            next_s.raw = l.result; // [RULE_17]
            next_s.station = bcd_bin; // [RULE_07] [RULE_08]
            next_s.defaulted = bcd_bad;
            next_s.id = l.result[`SRL_PARAM_BITS-1:`SRL_PARAM_ID_LSB]; // [RULE_05] [RULE_17]
            next_s.valid = 1'b1;
        end
        // a software set in the acknowledge cycle survives
        next_s.req = (s.req && !done_edge) || sw_set; // [RULE_10]
        if (s.req && !s.busy && mode_ok && !done_edge) begin // [RULE_09] [RULE_01]
            next_s.busy = 1'b1;
            next_s.req_tgl = !s.req_tgl;
        end
        next_s.match = s.valid && (destination_address == {1'b0, s.station}); // [RULE_08]
        if (accept && !hwrite) begin
            unique case (haddr[7:0])
                `SRL_OFS_CTRL: begin
                    next_s.hrdata[`SRL_CTRL_REQ_BIT] = s.req;
                end
                `SRL_OFS_STATUS: begin
                    next_s.hrdata[`SRL_STAT_BUSY_BIT] = s.busy;
                    next_s.hrdata[`SRL_STAT_MODE_BIT] = mode_ok;
                    next_s.hrdata[`SRL_STAT_VALID_BIT] = s.valid;
                    next_s.hrdata[`SRL_STAT_DFLT_BIT] = s.defaulted;
                end
                `SRL_OFS_PARAM: begin
                    next_s.hrdata[6:0] = s.station;
                    next_s.hrdata[`SRL_PARAM_BITS-1:`SRL_PARAM_ID_LSB] = s.id;
                end
                `SRL_OFS_RAW: begin
                    next_s.hrdata[`SRL_PARAM_BITS-1:0] = s.raw;
                end
                default: begin
                    // unmapped reads as zero
                    next_s.hrdata = 32'h0000_0000;
                end
            endcase
        end
        // a short reset is stretched, else the slow link side could miss it
        if (sys_rst || (s.rst_hold != 8'h00)) begin
            next_s = '0;
            next_s.req = 1'b1; // [RULE_11]
            next_s.link_hold = 1'b1;
            next_s.rst_hold = sys_rst ? `SRL_LINK_RST_CLKS : 8'(s.rst_hold - 8'h01);
        end
    end

    always_ff @(posedge clk) begin
        s <= next_s;
    end

    // link domain: one controller tick is DIV link cycles (250 kHz)
    assign lk_sample = ((l.st == SRL_LK_LOAD) || (l.st == SRL_LK_SHIFT))
        && (l.div == DIV_LAST); // [RULE_15]
    assign lk_start = (l.st == SRL_LK_IDLE) && (req_sync != l.req_seen);

    always_comb begin
        next_l = l;
        if (lk_sample) begin
            next_l.shreg = {sin, l.shreg[`SRL_PARAM_BITS-1:1]}; // [RULE_02] [RULE_03]
        end
        unique case (l.st)
            SRL_LK_IDLE: begin
                next_l.ce = `SRL_CE_IDLE;
                next_l.sclk = `SRL_SCLK_IDLE;
                next_l.pl = `SRL_PL_IDLE;
                if (lk_start) begin // [RULE_09]
                    next_l.req_seen = req_sync;
                    next_l.st = SRL_LK_LOAD;
                    next_l.div = 5'd0;
                    next_l.tick = 5'd0;
                    next_l.pl = 1'b0; // [RULE_14] [RULE_13]
                end
            end
            SRL_LK_LOAD: begin
                next_l.div = 5'(l.div + 5'd1);
                if (l.div == HALF_LAST) begin
                    next_l.pl = 1'b1;
                    next_l.ce = 1'b0; // [RULE_13]
                end
                if (lk_sample) begin
                    // first bit is already at the chain output after the load
                    next_l.div = 5'd0;
                    next_l.tick = 5'd1;
                    next_l.sclk = 1'b1; // [RULE_14]
                    next_l.st = SRL_LK_SHIFT;
                end
            end
            SRL_LK_SHIFT: begin
                next_l.div = 5'(l.div + 5'd1);
                if (l.div == HALF_LAST) begin
                    next_l.sclk = 1'b0; // [RULE_13]
                end
                if (lk_sample) begin
                    next_l.div = 5'd0;
                    if (l.tick == TICK_LAST) begin // [RULE_05] [RULE_16]
                        next_l.st = SRL_LK_DONE;
                    end else begin
                        next_l.tick = 5'(l.tick + 5'd1);
                        next_l.sclk = 1'b1;
                    end
                end
            end
            SRL_LK_DONE: begin
                next_l.result = l.shreg; // [RULE_17]
                next_l.done_tgl = !l.done_tgl; // [RULE_10]
                next_l.ce = `SRL_CE_IDLE;
                next_l.st = SRL_LK_IDLE;
            end
        endcase
        if (link_rst) begin
            next_l = '0;
            next_l.ce = `SRL_CE_IDLE; // [RULE_12]
            next_l.sclk = `SRL_SCLK_IDLE;
            next_l.pl = `SRL_PL_IDLE;
        end
    end

    always_ff @(posedge link_clk) begin
        l <= next_l;
    end

    // outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.hrdata;
    assign chain_clock_enable_out = l.ce;
    assign param_shift_clock = l.sclk;
    assign parallel_load_strobe = l.pl;
    assign station_address = s.station;
    assign id_number = s.id;
    assign param_valid = s.valid;
    assign address_match = s.match;
    assign shift_read_request = s.req;

    // checks, system domain
    property p_req_after_reset;
        @(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> s.req && !s.busy;
    endproperty
    a_req_after_reset: assert property (p_req_after_reset) // [RULE_11]
        else $error("request not raised after reset");

    property p_mode_gate;
        @(posedge clk) disable iff (sys_rst)
        !mode_ok |=> $stable(s.req_tgl);
    endproperty
    a_mode_gate: assert property (p_mode_gate) // [RULE_01]
        else $error("read launched outside shift register mode");

    property p_ack_clears;
        @(posedge clk) disable iff (sys_rst)
        (done_edge && !sw_set) |=> !s.req && !s.busy;
    endproperty
    a_ack_clears: assert property (p_ack_clears) // [RULE_10]
        else $error("request flag not cleared on completion");

    property p_default_addr;
        @(posedge clk) disable iff (sys_rst)
        (done_edge && bcd_bad) |=> (s.station == `SRL_ADDR_DEFAULT) && s.defaulted;
    endproperty
    a_default_addr: assert property (p_default_addr) // [RULE_07]
        else $error("illegal address not replaced by default");

    property p_bcd_conv;
        @(posedge clk) disable iff (sys_rst)
        (done_edge && !bcd_bad) |=> s.station ==
            7'(({3'b000, s.raw[7:4]} * `SRL_BCD_TEN) + {3'b000, s.raw[3:0]});
    endproperty
    a_bcd_conv: assert property (p_bcd_conv) // [RULE_08]
        else $error("bcd address converted wrongly");

    property p_param_hold;
        @(posedge clk) disable iff (sys_rst)
        !done_edge |=> $stable(s.id) && $stable(s.station);
    endproperty
    a_param_hold: assert property (p_param_hold) // [RULE_17]
        else $error("parameters changed without a completed read");

    // checks, link domain
    property p_reset_pins;
        @(posedge link_clk) disable iff (link_rst)
        $fell(link_rst) |-> l.ce && !l.sclk && l.pl;
    endproperty
    a_reset_pins: assert property (p_reset_pins) // [RULE_12]
        else $error("chain pins wrong after reset");

    property p_shift_in;
        @(posedge link_clk) disable iff (link_rst)
        lk_sample |=> l.shreg == {$past(sin), $past(l.shreg[`SRL_PARAM_BITS-1:1])};
    endproperty
    a_shift_in: assert property (p_shift_in) // [RULE_02]
        else $error("serial bit not shifted in at the top");

    property p_load_first;
        @(posedge link_clk) disable iff (link_rst)
        lk_start |=> !l.pl && !l.sclk ##1 (!l.sclk && l.st == SRL_LK_LOAD) [*8];
    endproperty
    a_load_first: assert property (p_load_first) // [RULE_14]
        else $error("shift clock before parallel load");

    property p_read_time;
        @(posedge link_clk) disable iff (link_rst)
        lk_start |-> ##[c_done_dly:c_done_dly] (l.st == SRL_LK_DONE);
    endproperty
    a_read_time: assert property (p_read_time) // [RULE_16]
        else $error("read cycle length wrong");

endmodule : srl_param_loader

// ==== srl_param_loader_tb_top.sv ====
// self-checking bench for the parameter loader, bus reads and chain traffic
// assumes the chain model file and srl_regs.svh are compiled alongside
`include "srl_regs.svh"
module srl_param_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic link_clk;
    logic sys_rst, hsel, hwrite, serial_param_select, eeprom_select;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, param_serial_in, ce, sclk, pl;
    logic [7:0] destination_address;
    logic [6:0] station_address;
    logic [15:0] id_number;
    logic param_valid, address_match, shift_read_request;
    logic [23:0] switches;
    int n_fail = 0;
    int checked = 0;
    int n_sclk = 0;
    int n_pl = 0;
    longint t_pl, t_ce, t_sc;

    always #2 clk = ~clk;

    // link clock runs free, phase unrelated to clk
    initial begin
        link_clk = 1'b0;
        #37;
        forever #80 link_clk = ~link_clk;
    end

    srl_param_loader i_srl_param_loader (
        .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .serial_param_select(serial_param_select), .eeprom_select(eeprom_select),
        .link_clk(link_clk), .param_serial_in(param_serial_in),
        .chain_clock_enable_out(ce), .param_shift_clock(sclk),
        .parallel_load_strobe(pl), .destination_address(destination_address),
        .station_address(station_address), .id_number(id_number),
        .param_valid(param_valid), .address_match(address_match),
        .shift_read_request(shift_read_request)
    );

    srl_chain_model i_srl_chain_model (
        .chain_clock_enable_out(ce), .param_shift_clock(sclk),
        .parallel_load_strobe(pl), .switches(switches),
        .param_serial_in(param_serial_in)
    );

    task automatic wrap_up();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one single transfer; read data taken at the data-phase edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        d = hrdata;
        chk(hresp, 1'b0);
    endtask : ahb

    function automatic logic [6:0] exp_st(input logic [7:0] b);
        if (b == 8'h00 || b[7:4] > 4'h9 || b[3:0] > 4'h9) begin
            return 7'h7e;
        end
        return 7'(b[7:4] * 10 + b[3:0]);
    endfunction : exp_st

    // chain monitor: pulse count, order and spacing
    always @(negedge pl) begin
        if (!sys_rst) begin
            n_sclk = 0;
            n_pl++;
            t_pl = $time;
        end
    end
    always @(posedge sclk) begin
        if (!sys_rst) begin
            chk(pl, 1'b1);
            if (n_sclk > 0) chk(32'($time - t_sc), 32'd4000);
            n_sclk++;
            t_sc = $time;
        end
    end
    always @(posedge ce) begin
        if (!sys_rst) t_ce = $time;
    end

    // waits bounded; a flag that never clears is reported by the compare
    task automatic check_read(input logic [23:0] sw, input logic dflt);
        int i;
        logic [6:0] e;
        e = exp_st(sw[7:0]);
        for (i = 0; i < 30000 && shift_read_request !== 1'b0; i++) @(posedge clk);
        chk(shift_read_request, 1'b0);
        chk(n_sclk, 23);
        chk(32'((t_ce - t_pl) > 95900 && (t_ce - t_pl) < 96400), 1);
        chk(station_address, e);
        chk(id_number, sw[23:8]);
        chk(param_valid, 1'b1);
        ahb(1'b0, `SRL_OFS_RAW, 32'h0, rd);
        chk(rd, {8'h00, sw});
        ahb(1'b0, `SRL_OFS_PARAM, 32'h0, rd);
        chk(rd, {8'h00, sw[23:8], 1'b0, e});
        ahb(1'b0, `SRL_OFS_STATUS, 32'h0, rd);
        chk(rd[3:0], {dflt, 3'b110});
        destination_address <= {1'b0, e};
        repeat (3) @(posedge clk);
        chk(address_match, 1'b1);
        destination_address <= {1'b0, e ^ 7'h01};
        repeat (3) @(posedge clk);
        chk(address_match, 1'b0);
    endtask : check_read

    initial begin
        #400000;
        n_fail++;
        wrap_up();
    end

    initial begin
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        serial_param_select = 1'b1;
        eeprom_select = 1'b0;
        destination_address = 8'h00;
        switches = {16'ha5c3, 8'h45};
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk(shift_read_request, 1'b1);
        // the loader stretches reset until the slow link side has seen it
        repeat (120) @(posedge clk);
        chk({ce, sclk, pl}, 3'b101);
        check_read({16'ha5c3, 8'h45}, 1'b0);
        // unmapped place: write ignored, read zero
        ahb(1'b1, 8'h10, 32'hffff_ffff, rd);
        ahb(1'b0, 8'h10, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        // bad bcd digit; old parameters hold until the last bit lands
        switches <= {16'h3c5a, 8'h4a};
        ahb(1'b1, `SRL_OFS_CTRL, 32'h0000_0001, rd);
        repeat (12000) @(posedge clk);
        chk(station_address, 7'd45);
        chk(param_valid, 1'b1);
        check_read({16'h3c5a, 8'h4a}, 1'b1);
        // eeprom path selected: request must wait
        eeprom_select <= 1'b1;
        switches <= {16'h0001, 8'h00};
        repeat (20) @(posedge clk);
        ahb(1'b1, `SRL_OFS_CTRL, 32'h0000_0001, rd);
        repeat (4000) @(posedge clk);
        chk(n_pl, 2);
        ahb(1'b0, `SRL_OFS_CTRL, 32'h0000_0000, rd);
        chk(rd[0], 1'b1);
        // serial memory not selected either: still no read
        eeprom_select <= 1'b0;
        serial_param_select <= 1'b0;
        repeat (4000) @(posedge clk);
        chk(n_pl, 2);
        ahb(1'b0, `SRL_OFS_STATUS, 32'h0000_0000, rd);
        chk(rd[1:0], 2'b00);
        serial_param_select <= 1'b1;
        check_read({16'h0001, 8'h00}, 1'b1);
        chk(n_pl, 3);
        wrap_up();
    end
endmodule : srl_param_loader_tb_top

// ==== srl_pkg.sv ====
// types shared by the parameter loader files
// assumes srl_regs.svh is on the include path
`include "srl_regs.svh"
package srl_pkg;

    // link sequencer states, gray along idle-load-shift-done
    typedef enum logic [1:0] {
        SRL_LK_IDLE = 2'b00,
        SRL_LK_LOAD = 2'b01,
        SRL_LK_SHIFT = 2'b11,
        SRL_LK_DONE = 2'b10
    } srl_lk_state_e;

    typedef struct packed {
        srl_lk_state_e st;
        logic [4:0] div;
        logic [4:0] tick;
        logic [`SRL_PARAM_BITS-1:0] shreg;
        logic [`SRL_PARAM_BITS-1:0] result;
        logic done_tgl;
        logic req_seen;
        logic ce;
        logic sclk;
        logic pl;
    } srl_lk_s;

    typedef struct packed {
        logic req;
        logic busy;
        logic req_tgl;
        logic done_seen;
        logic valid;
        logic defaulted;
        logic match;
        logic [6:0] station;
        logic [`SRL_ID_BITS-1:0] id;
        logic [`SRL_PARAM_BITS-1:0] raw;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
        logic link_hold;
        logic [7:0] rst_hold;
    } srl_sys_s;

endpackage : srl_pkg

// ==== srl_regs.svh ====
// constants for the parameter loader: register map, field positions, timing
// assumes a 250 MHz system clock and a free-running link clock of 6.25 MHz
`ifndef SRL_REGS_SVH
`define SRL_REGS_SVH

// register byte offsets within the slave window
`define SRL_OFS_CTRL 8'h00
`define SRL_OFS_STATUS 8'h04
`define SRL_OFS_PARAM 8'h08
`define SRL_OFS_RAW 8'h0c

// field positions
`define SRL_CTRL_REQ_BIT 0
`define SRL_STAT_BUSY_BIT 0
`define SRL_STAT_MODE_BIT 1
`define SRL_STAT_VALID_BIT 2
`define SRL_STAT_DFLT_BIT 3
`define SRL_PARAM_ID_LSB 8

// parameter word layout
`define SRL_ADDR_BITS 8
`define SRL_ID_BITS 16
`define SRL_PARAM_BITS 24
`define SRL_BCD_DIGIT_MAX 4'h9
`define SRL_BCD_TEN 7'h0a
`define SRL_ADDR_DEFAULT 7'h7e

// chain pin levels while idle and after reset
`define SRL_CE_IDLE 1'b1
`define SRL_SCLK_IDLE 1'b0
`define SRL_PL_IDLE 1'b1

// timing
`define SRL_LINK_CLK_KHZ 6250
`define SRL_CTRL_CLK_KHZ 250
`define SRL_READ_TIME_US 96
`define SRL_TICK_DIV (`SRL_LINK_CLK_KHZ / `SRL_CTRL_CLK_KHZ)
`define SRL_READ_TICKS ((`SRL_READ_TIME_US * `SRL_CTRL_CLK_KHZ) / 1000)
`define SRL_READ_CYCLES (`SRL_READ_TICKS * `SRL_TICK_DIV)
// reset stretch in system clocks; spans several link clock edges
`define SRL_LINK_RST_CLKS 8'hc0

`endif

// ==== srl_sync.sv ====
// two-flop synchroniser for one level
// assumes the input is asynchronous to clk
module srl_sync (
    // clock
    input wire logic clk,
    // level in and out
    input wire logic d,
    output logic q
);
    logic meta;

    // meta feeds only the second flop
    always_ff @(posedge clk) begin
        meta <= d;
        q <= meta;
    end
endmodule : srl_sync
